// [epo_energy_pulse_output.sv]
// two energy to frequency pulse outputs with metering interrupt registers
// Summary of operation
// - select bits 00 active, 01 reactive, 1x apparent or rms current
// - one shared mode bit picks apparent power or rms current
// - both outputs on the upper source always carry the same quantity
// - period above 180 ms gives fixed 90 ms low phase
// - period below 180 ms gives 50 percent duty
// - outputs are active low; pin driven low marks a pulse
// - each converter owns 16-bit numerator and denominator registers
// - ratio scales output from 1/65535 to 1 as numerator over denominator
// - zero in numerator or denominator acts as one
// - numerator above denominator clamps the ratio to one
// - unity scaling at full scale gives about 21.1 kHz
// - metering interrupt has its own vector at 0x004B
// - only events with enable bits set raise the interrupt
// - interrupt stays active until the causing status bit clears
// - writing zero to a status bit clears it
// - one internal pulse per energy lsb, scaled by the ratio
// - a set disable bit in the primary mode register stops an output
// - each output sets its own flag in the middle status register
module epo_energy_pulse_output #(
    parameter int unsigned LOW_CYCLES    = epo_pkg::LOW_CYCLES,
    parameter int unsigned PERIOD_CYCLES = epo_pkg::PERIOD_CYCLES
) (
    input  wire logic                 clock_in,
    input  wire logic                 srst_in,
    input  wire logic [7:0]           sfr_addr_in,
    input  wire logic [7:0]           sfr_wdata_in,
    input  wire logic                 sfr_wr_in,
    input  wire logic                 sfr_rd_in,
    output logic      [7:0]           sfr_rdata_out,
    input  wire epo_pkg::epo_energy_t energy_lsb_in,
    input  wire epo_pkg::epo_events_t meter_events_in,
    output logic                      pulse_output_one_n_out,
    output logic                      pulse_output_two_n_out,
    output logic                      meter_irq_out,
    output logic      [15:0]          meter_irq_vector_out
);
    logic [7:0]  primary_mode_config;
    logic [7:0]  pulse_mode_config;
    logic [7:0]  meter_irq_enable_low;
    logic [7:0]  meter_irq_enable_mid;
    logic [7:0]  meter_irq_enable_high;
    logic [7:0]  meter_irq_status_low;
    logic [7:0]  meter_irq_status_mid;
    logic [7:0]  meter_irq_status_high;
    logic [15:0] freq_numerator   [2];
    logic [15:0] freq_denominator [2];

    logic [1:0]  pulse_source_select [2];
    logic        current_rms_pulse_select;
    logic [1:0]  pulse_disable;
    logic [1:0]  src_pulse;
    logic [1:0]  cf_fire;
    logic [1:0]  pin_n;
    logic [7:0]  cf_status_bits;
    logic [7:0]  next_status_low;
    logic [7:0]  next_status_mid;
    logic [7:0]  next_status_high;
    logic        freq_hit;
    logic        freq_ch;
    logic [23:0] status_all;
    logic [23:0] enable_all;

    assign current_rms_pulse_select = pulse_mode_config[epo_pkg::PULSE_MODE_CONFIG_RMS_BIT];
    assign freq_hit = (sfr_addr_in[7:3] == epo_pkg::ADDR_FREQ_BASE[7:3]);
    assign freq_ch  = sfr_addr_in[2];
    assign status_all = {meter_irq_status_high, meter_irq_status_mid, meter_irq_status_low};
    assign enable_all = {meter_irq_enable_high, meter_irq_enable_mid, meter_irq_enable_low};

    // mode and enable registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            primary_mode_config   <= epo_pkg::BYTE_RESET;
            pulse_mode_config     <= epo_pkg::BYTE_RESET;
            meter_irq_enable_low  <= epo_pkg::BYTE_RESET;
            meter_irq_enable_mid  <= epo_pkg::BYTE_RESET;
            meter_irq_enable_high <= epo_pkg::BYTE_RESET;
        end else if (sfr_wr_in) begin
            case (sfr_addr_in)
                epo_pkg::ADDR_PRIMARY_MODE_CONFIG:   primary_mode_config   <= sfr_wdata_in;
                epo_pkg::ADDR_PULSE_MODE_CONFIG:   pulse_mode_config     <= sfr_wdata_in;
                epo_pkg::ADDR_EN_LOW:  meter_irq_enable_low  <= sfr_wdata_in;
                epo_pkg::ADDR_EN_MID:  meter_irq_enable_mid  <= sfr_wdata_in;
                epo_pkg::ADDR_EN_HIGH: meter_irq_enable_high <= sfr_wdata_in;
                default: begin
                end
            endcase
        end
    end

    // per converter: scaling registers, source pick, scaler and shaper
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_conv
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    freq_numerator[ch]   <= epo_pkg::FREQ_RESET;
                    freq_denominator[ch] <= epo_pkg::FREQ_RESET;
                end else if (sfr_wr_in && freq_hit && freq_ch == ch) begin
                    case (sfr_addr_in[1:0])
                        epo_pkg::FREQ_NUM_LO: freq_numerator[ch][7:0]    <= sfr_wdata_in;
                        epo_pkg::FREQ_NUM_HI: freq_numerator[ch][15:8]   <= sfr_wdata_in;
                        epo_pkg::FREQ_DEN_LO: freq_denominator[ch][7:0]  <= sfr_wdata_in;
                        epo_pkg::FREQ_DEN_HI: freq_denominator[ch][15:8] <= sfr_wdata_in;
                        default: begin
                        end
                    endcase
                end
            end

            assign pulse_source_select[ch] =
                pulse_mode_config[epo_pkg::PULSE_MODE_CONFIG_SEL_LSB + 2*ch +: 2];
            assign pulse_disable[ch] = primary_mode_config[epo_pkg::PRIMARY_MODE_CONFIG_DIS_LSB + ch];

            // one shared bit for both outputs keeps apparent and rms from mixing
            always_comb begin
                case (pulse_source_select[ch])
                    epo_pkg::SEL_ACTIVE:   src_pulse[ch] = energy_lsb_in.active;
                    epo_pkg::SEL_REACTIVE: src_pulse[ch] = energy_lsb_in.reactive;
                    default: begin
                        src_pulse[ch] = current_rms_pulse_select ?
                                        energy_lsb_in.irms : energy_lsb_in.apparent;
                    end
                endcase
            end

            // with unity scaling the output rate equals the source lsb rate
            epo_dfc u_dfc (
                .clock_in       (clock_in),
                .srst_in        (srst_in),
                .enable_in      (!pulse_disable[ch]),
                .pulse_in       (src_pulse[ch]),
                .numerator_in   (freq_numerator[ch]),
                .denominator_in (freq_denominator[ch]),
                .pulse_out      (cf_fire[ch])
            );

            epo_pulse_shaper #(
                .LOW_CYCLES    (LOW_CYCLES),
                .PERIOD_CYCLES (PERIOD_CYCLES)
            ) u_shaper (
                .clock_in    (clock_in),
                .srst_in     (srst_in),
                .enable_in   (!pulse_disable[ch]),
                .fire_in     (cf_fire[ch]),
                .pulse_n_out (pin_n[ch])
            );

            disabled_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
                (pulse_disable[ch] [*2]) |-> (pin_n[ch] && !cf_fire[ch]))
                else $error("disabled output still pulsing");
            flag_set_a: assert property (@(posedge clock_in) disable iff (srst_in)
                cf_fire[ch] |=> meter_irq_status_mid[epo_pkg::ST_MID_CF_LSB + ch])
                else $error("pulse did not set its status flag");
        end
    endgenerate

    assign pulse_output_one_n_out = pin_n[0];
    assign pulse_output_two_n_out = pin_n[1];

    always_comb begin
        cf_status_bits = 8'h00;
        cf_status_bits[epo_pkg::ST_MID_CF_LSB +: 2] = cf_fire;
    end

    // write zero clears, write one keeps; a new event wins over the clear
    always_comb begin
        next_status_low  = meter_irq_status_low;
        next_status_mid  = meter_irq_status_mid;
        next_status_high = meter_irq_status_high;
        if (sfr_wr_in && sfr_addr_in == epo_pkg::ADDR_ST_LOW) begin
            next_status_low = meter_irq_status_low & sfr_wdata_in;
        end
        if (sfr_wr_in && sfr_addr_in == epo_pkg::ADDR_ST_MID) begin
            next_status_mid = meter_irq_status_mid & sfr_wdata_in;
        end
        if (sfr_wr_in && sfr_addr_in == epo_pkg::ADDR_ST_HIGH) begin
            next_status_high = meter_irq_status_high & sfr_wdata_in;
        end
        next_status_low  = next_status_low | meter_events_in.low;
        next_status_mid  = next_status_mid | meter_events_in.mid | cf_status_bits;
        next_status_high = next_status_high | meter_events_in.high;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            meter_irq_status_low  <= epo_pkg::BYTE_RESET;
            meter_irq_status_mid  <= epo_pkg::BYTE_RESET;
            meter_irq_status_high <= epo_pkg::BYTE_RESET;
        end else begin
            meter_irq_status_low  <= next_status_low;
            meter_irq_status_mid  <= next_status_mid;
            meter_irq_status_high <= next_status_high;
        end
    end

    // request held as long as any enabled status bit stays set
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            meter_irq_out <= 1'b0;
        end else begin
            meter_irq_out <= |(status_all & enable_all);
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            meter_irq_vector_out <= 16'h0000;
        end else begin
            meter_irq_vector_out <= epo_pkg::METER_IRQ_VECTOR;
        end
    end

    // read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sfr_rdata_out <= epo_pkg::BYTE_RESET;
        end else if (sfr_rd_in) begin
            if (freq_hit) begin
                case (sfr_addr_in[1:0])
                    epo_pkg::FREQ_NUM_LO: sfr_rdata_out <= freq_numerator[freq_ch][7:0];
                    epo_pkg::FREQ_NUM_HI: sfr_rdata_out <= freq_numerator[freq_ch][15:8];
                    epo_pkg::FREQ_DEN_LO: sfr_rdata_out <= freq_denominator[freq_ch][7:0];
                    default:              sfr_rdata_out <= freq_denominator[freq_ch][15:8];
                endcase
            end else begin
                case (sfr_addr_in)
                    epo_pkg::ADDR_PRIMARY_MODE_CONFIG:   sfr_rdata_out <= primary_mode_config;
                    epo_pkg::ADDR_PULSE_MODE_CONFIG:   sfr_rdata_out <= pulse_mode_config;
                    epo_pkg::ADDR_EN_LOW:  sfr_rdata_out <= meter_irq_enable_low;
                    epo_pkg::ADDR_EN_MID:  sfr_rdata_out <= meter_irq_enable_mid;
                    epo_pkg::ADDR_EN_HIGH: sfr_rdata_out <= meter_irq_enable_high;
                    epo_pkg::ADDR_ST_LOW:  sfr_rdata_out <= meter_irq_status_low;
                    epo_pkg::ADDR_ST_MID:  sfr_rdata_out <= meter_irq_status_mid;
                    epo_pkg::ADDR_ST_HIGH: sfr_rdata_out <= meter_irq_status_high;
                    default:               sfr_rdata_out <= epo_pkg::BYTE_RESET;
                endcase
            end
        end
    end

    src_active_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (pulse_source_select[0] == epo_pkg::SEL_ACTIVE && !pulse_disable[0]
         && energy_lsb_in.active && freq_numerator[0] == freq_denominator[0])
        |=> cf_fire[0])
        else $error("active source pulse lost on output one");
    shared_source_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (pulse_source_select[0][1] && pulse_source_select[1][1])
        |-> (src_pulse[0] == src_pulse[1]))
        else $error("outputs carry apparent and rms at once");
    irq_enabled_a: assert property (@(posedge clock_in) disable iff (srst_in)
        meter_irq_out |-> (|($past(status_all) & $past(enable_all))))
        else $error("interrupt without enabled status bit");
    // a write one cycle earlier already reaches the request, so it is excluded too
    irq_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (!sfr_wr_in ##1 (meter_irq_out && !sfr_wr_in)) |=> meter_irq_out)
        else $error("interrupt dropped without a clearing write");
    clear_zero_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (sfr_wr_in && sfr_addr_in == epo_pkg::ADDR_ST_LOW && !sfr_wdata_in[0]
         && !meter_events_in.low[0]) |=> !meter_irq_status_low[0])
        else $error("zero write did not clear status bit");
    irq_or_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (|(status_all & enable_all)) |=> meter_irq_out)
        else $error("enabled status bit did not raise interrupt");

endmodule

// [epo_pkg.sv]
// constants and types shared by the energy pulse output block
package epo_pkg;

    // clock and pulse timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned LOW_TIME_MS     = 90;
    localparam int unsigned PERIOD_LIMIT_MS = 180;
    localparam int unsigned LOW_CYCLES      = LOW_TIME_MS * CLK_PER_MS;
    localparam int unsigned PERIOD_CYCLES   = PERIOD_LIMIT_MS * CLK_PER_MS;
    localparam int unsigned CNT_W           = 25;

    // full-scale output rate with unity scaling, for reference only
    localparam int unsigned MAX_FREQ_HZ     = 21_100;

    // register addresses
    localparam logic [7:0] ADDR_PRIMARY_MODE_CONFIG     = 8'h0B;
    localparam logic [7:0] ADDR_PULSE_MODE_CONFIG     = 8'h0C;
    localparam logic [7:0] ADDR_EN_LOW    = 8'hD9;
    localparam logic [7:0] ADDR_EN_MID    = 8'hDA;
    localparam logic [7:0] ADDR_EN_HIGH   = 8'hDB;
    localparam logic [7:0] ADDR_ST_LOW    = 8'hDC;
    localparam logic [7:0] ADDR_ST_MID    = 8'hDD;
    localparam logic [7:0] ADDR_ST_HIGH   = 8'hDE;
    localparam logic [7:0] ADDR_FREQ_BASE = 8'h40;

    // byte position inside one converter's four-byte scaling group
    localparam logic [1:0] FREQ_NUM_LO = 2'h0;
    localparam logic [1:0] FREQ_NUM_HI = 2'h1;
    localparam logic [1:0] FREQ_DEN_LO = 2'h2;
    localparam logic [1:0] FREQ_DEN_HI = 2'h3;

    // field positions
    localparam int unsigned PRIMARY_MODE_CONFIG_DIS_LSB  = 0;
    localparam int unsigned PULSE_MODE_CONFIG_RMS_BIT  = 3;
    localparam int unsigned PULSE_MODE_CONFIG_SEL_LSB  = 4;
    localparam int unsigned ST_MID_CF_LSB  = 6;

    // source select codes
    localparam logic [1:0] SEL_ACTIVE   = 2'h0;
    localparam logic [1:0] SEL_REACTIVE = 2'h1;

    // reset values
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] FREQ_RESET = 16'h0000;

    // processor vector serving metering interrupts
    localparam logic [15:0] METER_IRQ_VECTOR = 16'h004B;

    typedef struct packed {
        logic active;
        logic reactive;
        logic apparent;
        logic irms;
    } epo_energy_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] mid;
        logic [7:0] low;
    } epo_events_t;

    typedef enum logic [1:0] {
        SH_HIGH = 2'b01,
        SH_LOW  = 2'b10
    } epo_shape_state_t;

endpackage

// [epo_dfc.sv]
// numerator over denominator pulse scaler for one converter
module epo_dfc (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        enable_in,
    input  wire logic        pulse_in,
    input  wire logic [15:0] numerator_in,
    input  wire logic [15:0] denominator_in,
    output logic             pulse_out
);
    logic [15:0] num_eff;
    logic [15:0] den_eff;
    logic [16:0] acc;
    logic [16:0] sum;

    always_comb begin
        num_eff = (numerator_in == 16'h0000) ? 16'h0001 : numerator_in;
        den_eff = (denominator_in == 16'h0000) ? 16'h0001 : denominator_in;
        if (num_eff > den_eff) begin
            num_eff = den_eff;
        end
        sum = acc + {1'b0, num_eff};
    end

    // acc stays below den_eff, so one input never yields two outputs
    always_ff @(posedge clock_in) begin
        if (srst_in || !enable_in) begin
            acc       <= 17'h00000;
            pulse_out <= 1'b0;
        end else if (pulse_in) begin
            if (sum >= {1'b0, den_eff}) begin
                acc       <= sum - {1'b0, den_eff};
                pulse_out <= 1'b1;
            end else begin
                acc       <= sum;
                pulse_out <= 1'b0;
            end
        end else begin
            pulse_out <= 1'b0;
        end
    end

    clamp_unity_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (enable_in && pulse_in && num_eff == den_eff) |=> pulse_out)
        else $error("unity ratio did not pass every pulse");
    pulse_cause_a: assert property (@(posedge clock_in) disable iff (srst_in)
        pulse_out |-> $past(pulse_in))
        else $error("output pulse without internal pulse");

endmodule

// [epo_pulse_shaper.sv]
// active-low pulse width shaper for one output pin
module epo_pulse_shaper #(
    parameter int unsigned LOW_CYCLES    = epo_pkg::LOW_CYCLES,
    parameter int unsigned PERIOD_CYCLES = epo_pkg::PERIOD_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic srst_in,
    input  wire logic enable_in,
    input  wire logic fire_in,
    output logic      pulse_n_out
);
    localparam logic [epo_pkg::CNT_W-1:0] LOW_LEN = LOW_CYCLES[epo_pkg::CNT_W-1:0];
    localparam logic [epo_pkg::CNT_W-1:0] PER_LIM = PERIOD_CYCLES[epo_pkg::CNT_W-1:0];
    localparam logic [epo_pkg::CNT_W-1:0] ONE     = {{(epo_pkg::CNT_W-1){1'b0}}, 1'b1};

    epo_pkg::epo_shape_state_t   state;
    logic [epo_pkg::CNT_W-1:0]   period_cnt;
    logic [epo_pkg::CNT_W-1:0]   low_cnt;
    logic [epo_pkg::CNT_W-1:0]   next_len;
    logic [epo_pkg::CNT_W-1:0]   low_run;
    logic [epo_pkg::CNT_W-1:0]   exp_len;
    logic                        exp_long;

    // low time follows the last measured period
    always_comb begin
        if (period_cnt >= PER_LIM) begin
            next_len = LOW_LEN;
        end else if ((period_cnt >> 1) == '0) begin
            next_len = ONE;
        end else begin
            next_len = period_cnt >> 1;
        end
    end

    // saturates so a first pulse or a slow load gets the fixed low time
    always_ff @(posedge clock_in) begin
        if (srst_in || !enable_in) begin
            period_cnt <= PER_LIM;
        end else if (fire_in) begin
            period_cnt <= ONE;
        end else if (period_cnt < PER_LIM) begin
            period_cnt <= period_cnt + ONE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || !enable_in) begin
            state       <= epo_pkg::SH_HIGH;
            low_cnt     <= '0;
            pulse_n_out <= 1'b1;
        end else if (fire_in) begin
            state       <= epo_pkg::SH_LOW;
            low_cnt     <= next_len;
            pulse_n_out <= 1'b0;
        end else begin
            case (state)
                epo_pkg::SH_LOW: begin
                    if (low_cnt <= ONE) begin
                        state       <= epo_pkg::SH_HIGH;
                        pulse_n_out <= 1'b1;
                    end else begin
                        low_cnt <= low_cnt - ONE;
                    end
                end
                epo_pkg::SH_HIGH: begin
                    pulse_n_out <= 1'b1;
                end
                default: begin
                    state       <= epo_pkg::SH_HIGH;
                    pulse_n_out <= 1'b1;
                end
            endcase
        end
    end

    // helper that measures each low phase for the checks below
    always_ff @(posedge clock_in) begin
        if (srst_in || fire_in) begin
            low_run  <= '0;
            exp_len  <= next_len;
            exp_long <= (period_cnt >= PER_LIM);
        end else if (!pulse_n_out) begin
            low_run <= low_run + ONE;
        end
    end

    long_low_a: assert property (@(posedge clock_in) disable iff (srst_in)
        ($rose(pulse_n_out) && $past(enable_in) && exp_long) |-> (low_run == LOW_LEN))
        else $error("long period pulse low time wrong");
    half_duty_a: assert property (@(posedge clock_in) disable iff (srst_in)
        ($rose(pulse_n_out) && $past(enable_in) && !exp_long) |-> (low_run == exp_len))
        else $error("short period pulse not half duty");

endmodule

// [epo_cal_meter.sv]
// calibration meter model counting pulses on both led pins and the low width on pin one
module epo_cal_meter (
    input  wire logic        clock_in,
    input  wire logic        pin_one_n_in,
    input  wire logic        pin_two_n_in,
    output logic      [15:0] count_one_out,
    output logic      [15:0] count_two_out,
    output logic      [15:0] width_one_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        last_one;
    logic        last_two;
    logic [15:0] run_one;
    initial begin
        {count_one_out, count_two_out, width_one_out, run_one} = '0;
        {last_one, last_two} = 2'h3;
    end
    // the optical input lights only while a pin is low
    always @(posedge clock_in) begin
        last_one <= pin_one_n_in;
        last_two <= pin_two_n_in;
        if (!pin_one_n_in) run_one <= run_one + 16'h0001;
        if (last_one && !pin_one_n_in) count_one_out <= count_one_out + 16'h0001;
        if (last_two && !pin_two_n_in) count_two_out <= count_two_out + 16'h0001;
        if (!last_one && pin_one_n_in) begin
            width_one_out <= run_one;
            run_one <= 16'h0000;
        end
    end
endmodule

// [epo_energy_pulse_output_bench.sv]
// self-checking bench for the energy pulse output block
module epo_energy_pulse_output_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOW = 20;
    typedef struct packed {
        logic [7:0] mode; logic [15:0] num; logic [15:0] den;
        logic [3:0] src; logic [7:0] n; logic [7:0] e1; logic [7:0] e2;
    } epo_row_t;
    logic clock_in, srst_in, sfr_wr_in, sfr_rd_in, pin_one_n, pin_two_n, irq;
    logic [7:0]  sfr_addr_in, sfr_wdata_in, rdata;
    logic [15:0] vector, count_one, count_two, width_one;
    epo_pkg::epo_energy_t energy;
    epo_pkg::epo_events_t events;
    int fail_count = 0;
    int comparisons = 0;
    epo_energy_pulse_output #(.LOW_CYCLES(LOW), .PERIOD_CYCLES(2 * LOW)) u_epo_energy_pulse_output (
        .clock_in(clock_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(rdata), .energy_lsb_in(energy), .meter_events_in(events),
        .pulse_output_one_n_out(pin_one_n), .pulse_output_two_n_out(pin_two_n),
        .meter_irq_out(irq), .meter_irq_vector_out(vector));
    epo_cal_meter u_epo_cal_meter (.clock_in(clock_in), .pin_one_n_in(pin_one_n),
        .pin_two_n_in(pin_two_n), .count_one_out(count_one), .count_two_out(count_two),
        .width_one_out(width_one));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in) #1 {sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {a, d, 1'b1};
        @(posedge clock_in) #1 sfr_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in) #1 {sfr_addr_in, sfr_rd_in} = {a, 1'b1};
        @(posedge clock_in) #1 sfr_rd_in = 1'b0;
        d = rdata;
    endtask
    task automatic pulse(input logic [3:0] src, input int n, input int gap);
        repeat (n) begin
            @(posedge clock_in) #1 energy = src;
            @(posedge clock_in) #1 energy = 4'h0;
            repeat (gap) @(posedge clock_in);
        end
        repeat (30) @(posedge clock_in);
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        close_out();
    end
    initial begin
        epo_row_t    rows [9];
        logic [7:0]  regs [6];
        logic [31:0] sc;
        logic [15:0] c1, c2;
        logic [7:0]  d;
        rows = '{
            '{8'h00, 16'h0000, 16'h0000, 4'h8, 8'h04, 8'h04, 8'h04},
            '{8'h10, 16'h0000, 16'h0000, 4'h4, 8'h04, 8'h04, 8'h00},
            '{8'h40, 16'h0000, 16'h0000, 4'h4, 8'h04, 8'h00, 8'h04},
            '{8'hE0, 16'h0000, 16'h0000, 4'h2, 8'h04, 8'h04, 8'h04},
            '{8'hE8, 16'h0000, 16'h0000, 4'h1, 8'h04, 8'h04, 8'h04},
            '{8'hE8, 16'h0000, 16'h0000, 4'h2, 8'h04, 8'h00, 8'h00},
            '{8'h00, 16'h0001, 16'h0002, 4'h8, 8'h04, 8'h02, 8'h02},
            '{8'h00, 16'h0005, 16'h0003, 4'h8, 8'h04, 8'h04, 8'h04},
            '{8'h00, 16'h0000, 16'h0003, 4'h8, 8'h06, 8'h02, 8'h02}};
        regs = '{8'h0B, 8'h0C, 8'hD9, 8'hDA, 8'hDB, 8'h40};
        {srst_in, sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = {1'b1, 18'h00000};
        {energy, events} = '0;
        repeat (16) @(posedge clock_in);
        #1 srst_in = 1'b0;
        @(posedge clock_in);
        #1 check(vector, 16'h004B);
        check({15'h0000, pin_one_n & pin_two_n}, 16'h0001);
        foreach (regs[k]) begin
            rd(regs[k], d);
            check({8'h00, d}, 16'h0000);
        end
        foreach (rows[i]) begin
            wr(8'h0C, rows[i].mode);
            sc = {rows[i].den, rows[i].num};
            for (int k = 0; k < 8; k++) wr(8'h40 + 8'(k), 8'(sc >> (8 * (k % 4))));
            {c1, c2} = {count_one, count_two};
            pulse(rows[i].src, int'(rows[i].n), 60);
            check(count_one - c1, {8'h00, rows[i].e1});
            check(count_two - c2, {8'h00, rows[i].e2});
            check(width_one, 16'(LOW));
        end
        // last row left a one in three ratio; later cases expect one output per input
        wr(8'h42, 8'h00);
        wr(8'h46, 8'h00);
        rd(8'hDD, d);
        check({14'h0000, d[7:6]}, 16'h0003);
        wr(8'hDD, 8'h00);
        rd(8'hDD, d);
        check({8'h00, d}, 16'h0000);
        wr(8'hDA, 8'h40);
        pulse(4'h8, 1, 10);
        check({15'h0000, irq}, 16'h0001);
        repeat (50) @(posedge clock_in);
        check({15'h0000, irq}, 16'h0001);
        wr(8'hDD, 8'h00);
        repeat (3) @(posedge clock_in);
        check({15'h0000, irq}, 16'h0000);
        @(posedge clock_in) #1 events = 24'h000001;
        @(posedge clock_in) #1 events = 24'h000000;
        repeat (3) @(posedge clock_in);
        check({15'h0000, irq}, 16'h0000);
        wr(8'hD9, 8'h01);
        repeat (3) @(posedge clock_in);
        check({15'h0000, irq}, 16'h0001);
        wr(8'hDC, 8'h00);
        repeat (3) @(posedge clock_in);
        check({15'h0000, irq}, 16'h0000);
        // a disabled pin must stay dark while its neighbour still counts
        wr(8'h0B, 8'h01);
        {c1, c2} = {count_one, count_two};
        pulse(4'h8, 2, 60);
        check(count_one - c1, 16'h0000);
        check(count_two - c2, 16'h0002);
        wr(8'h0B, 8'h00);
        pulse(4'h8, 6, 10);
        check(width_one, 16'h0006);
        wr(8'h48, 8'hFF);
        rd(8'h48, d);
        check({8'h00, d}, 16'h0000);
        close_out();
    end
endmodule
